// ### irq_opt_pkg.sv
/*
 Constants for the interrupt and option control register bank:
 register indices, field positions, reset values and bus layout.
 Assumes a bus slave that places each register index on a 32-bit word.
*/
package irq_opt_pkg;
	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_INDIRECT = 8'h00;
	localparam logic [7:0] IDX_INTR_CTRL = 8'h0B;
	localparam logic [7:0] IDX_CONV_CTRL = 8'h08;
	localparam logic [7:0] IDX_OPTION = 8'h81;
	localparam logic [7:0] IDX_PORTA_DIR = 8'h85;
	localparam logic [7:0] IDX_PORTB_DIR = 8'h86;
	localparam logic [7:0] IDX_ANALOG_CFG = 8'h88;
	localparam logic [7:0] IDX_UPPER_BASE = 8'h80;
	localparam logic [7:0] IDX_UPPER_LAST = 8'h8B;
	localparam logic [7:0] PAGE_BIT_MASK = 8'h7F;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;

	// Interrupt control fields
	localparam int IC_RB_FLAG = 0;
	localparam int IC_EXT_FLAG = 1;
	localparam int IC_TMR_FLAG = 2;
	localparam int IC_RB_EN = 3;
	localparam int IC_EXT_EN = 4;
	localparam int IC_TMR_EN = 5;
	localparam int IC_CONV_EN = 6;
	localparam int IC_GLOBAL_EN = 7;

	// Converter control: completion flag position
	localparam int CC_DONE_FLAG = 1;

	// Option fields
	localparam int OPT_RATIO_LSB = 0;
	localparam int OPT_RATIO_W = 3;
	localparam int OPT_ASSIGN_WDT = 3;
	localparam int OPT_CNT_EDGE = 4;
	localparam int OPT_CNT_SRC = 5;
	localparam int OPT_INT_EDGE = 6;
	localparam int OPT_PULLUP_OFF = 7;

	// Port B pins watched for change
	localparam int RB_WATCH_LO = 4;
	localparam int RB_WATCH_HI = 7;

	// Analog configuration codes
	localparam logic [1:0] AN_ALL_VDD = 2'h0;
	localparam logic [1:0] AN_ALL_EXTREF = 2'h1;
	localparam logic [1:0] AN_TWO = 2'h2;
	localparam logic [1:0] AN_NONE = 2'h3;

	// Reset values
	localparam logic [7:0] RST_INTR_CTRL = 8'h00;
	localparam logic [7:0] RST_CONV_CTRL = 8'h00;
	localparam logic [7:0] RST_OPTION = 8'hFF;
	localparam logic [7:0] RST_DIR = 8'hFF;
	localparam logic [7:0] RST_ANALOG_CFG = 8'h00;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_WAIT = 2'b01,
		BUS_DONE = 2'b10
	} bus_state_t;
endpackage

// ### irq_opt_ctrl.sv
/*
 Interrupt control, option, port direction and analog configuration
 registers of a small controller, reached over APB.
 Assumes pin inputs synchronous to CLK_SYS, and the counter, watchdog
 and converter datapaths outside, giving one-cycle event pulses.
*/
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps

// How it works
// - Port B upper change sets bit 0
// - Selected external edge sets bit 1
// - Counter overflow sets bit 2
// - Bits 3-6 enable individual sources
// - Bit 7 gates all interrupts
// - Counter ratio 1:2 up to 1:256
// - Watchdog ratio 1:1 up to 1:128
// - Option bit 3 assigns the prescaler
// - Option bit 4 picks counter pin edge
// - Option bit 5 picks counter source
// - Option bit 6 picks interrupt edge
// - Option bit 7 turns pull-ups off
// - Port A direction: one input, zero output
// - Port B direction register, same convention
// - Two-bit field sets analog pins, reference
// - Upper-page mirrors alias lower-page registers
// - Change watch pins 4-7, inputs; wakes
// - Converter flag bit 1, enabled by 6
module irq_opt_ctrl
	import irq_opt_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RSTN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic [DATA_W-1:0] PWDATA,
	output logic [DATA_W-1:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [7:0] PORTB_PINS,
	input wire logic EXT_INT_PIN,
	input wire logic COUNTER_PIN,
	input wire logic INSTR_TICK,
	input wire logic WDT_TICK,
	input wire logic COUNTER_OVERFLOW,
	input wire logic CONVERSION_DONE,
	output logic IRQ,
	output logic WAKE_REQ,
	output logic COUNTER_INC,
	output logic WDT_INC,
	output logic [7:0] PORTA_DIR,
	output logic [7:0] PORTB_DIR,
	output logic [7:0] PORTB_PULLUP,
	output logic [3:0] PORTA_ANALOG,
	output logic EXT_VREF
);

	// Mask of the prescaler counter for a ratio code
	function automatic logic [7:0] ratio_mask(
		input logic [2:0] code,
		input logic to_wdt
	);
		logic [8:0] full;
		full = 9'h001 << code;
		if (!to_wdt)
		begin
			full = {full[7:0], 1'b0};
		end
		ratio_mask = full[7:0] - 8'h01;
	endfunction

	// Fold an upper-page mirror onto its lower-page index
	function automatic logic [7:0] fold_index(input logic [7:0] idx);
		logic mirror;
		mirror = (idx == IDX_UPPER_BASE) || (idx == 8'h82)
			|| (idx == 8'h83) || (idx == 8'h84) || (idx == 8'h89)
			|| (idx == 8'h8A) || (idx == IDX_UPPER_LAST);
		fold_index = mirror ? (idx & PAGE_BIT_MASK) : idx;
	endfunction

	// Bus handshake state
	bus_state_t bus_state_r;
	bus_state_t bus_state_nxt;
	logic [7:0] intr_ctrl_r;
	logic [7:0] intr_ctrl_nxt;
	logic [7:0] conv_ctrl_r;
	logic [7:0] conv_ctrl_nxt;
	logic [7:0] option_r;
	logic [7:0] porta_dir_r;
	logic [7:0] portb_dir_r;
	logic [7:0] analog_cfg_r;
	// Pin history for edge detection
	logic [7:0] portb_prev_r;
	logic ext_prev_r;
	logic cnt_pin_prev_r;
	logic prev_valid_r;
	logic [7:0] pre_cnt_r;
	logic [7:0] pre_cnt_nxt;
	logic [DATA_W-1:0] prdata_r;
	logic pslverr_r;
	// Registered outputs
	logic irq_r;
	logic wake_r;
	logic cnt_inc_r;
	logic wdt_inc_r;

	// Address decode
	wire logic [7:0] raw_index = PADDR[ADDR_W-1:2];
	wire logic [7:0] index = fold_index(raw_index);
	wire logic aligned = (PADDR[1:0] == 2'b00);
	wire logic hit_ic = aligned && (index == IDX_INTR_CTRL);
	wire logic hit_cc = aligned && (index == IDX_CONV_CTRL);
	wire logic hit_opt = aligned && (index == IDX_OPTION);
	wire logic hit_pa = aligned && (index == IDX_PORTA_DIR);
	wire logic hit_pb = aligned && (index == IDX_PORTB_DIR);
	wire logic hit_an = aligned && (index == IDX_ANALOG_CFG);
	wire logic mapped = hit_ic || hit_cc || hit_opt || hit_pa
		|| hit_pb || hit_an;
	wire logic [7:0] wbyte = PWDATA[7:0];

	// Bus sequencing: two wait states so read data leaves a flip-flop
	wire logic access = PSEL && PENABLE;
	wire logic commit = access && (bus_state_r == BUS_DONE);
	wire logic wr_commit = commit && PWRITE && mapped;
	wire logic wr_ic = wr_commit && hit_ic;
	wire logic wr_cc = wr_commit && hit_cc;
	wire logic wr_opt = wr_commit && hit_opt;

	// Unmapped or misaligned reads give zero
	wire logic [7:0] read_byte =
		hit_ic ? intr_ctrl_r :
		hit_cc ? conv_ctrl_r :
		hit_opt ? option_r :
		hit_pa ? porta_dir_r :
		hit_pb ? portb_dir_r :
		hit_an ? analog_cfg_r : 8'h00;

	// Fixed two wait states; ready never depends on inputs
	always_comb
	begin
		bus_state_nxt = bus_state_r;
		case (bus_state_r)
			BUS_IDLE:
			begin
				if (access)
				begin
					bus_state_nxt = BUS_WAIT;
				end
			end
			BUS_WAIT:
			begin
				bus_state_nxt = BUS_DONE;
			end
			BUS_DONE:
			begin
				bus_state_nxt = BUS_IDLE;
			end
			default:
			begin
				bus_state_nxt = BUS_IDLE;
			end
		endcase
	end

	// Event detection; the first cycle after reset has no history
	wire logic [3:0] rb_watch_dir = portb_dir_r[RB_WATCH_HI:RB_WATCH_LO];
	wire logic [3:0] rb_diff =
		PORTB_PINS[RB_WATCH_HI:RB_WATCH_LO]
		^ portb_prev_r[RB_WATCH_HI:RB_WATCH_LO];
	// Output pins are excluded from the change watch
	wire logic rb_change = prev_valid_r
		&& |(rb_diff & rb_watch_dir);
	wire logic ext_rise = EXT_INT_PIN && !ext_prev_r;
	wire logic ext_fall = !EXT_INT_PIN && ext_prev_r;
	wire logic ext_event = prev_valid_r
		&& (option_r[OPT_INT_EDGE] ? ext_rise : ext_fall);
	wire logic cnt_rise = COUNTER_PIN && !cnt_pin_prev_r;
	wire logic cnt_fall = !COUNTER_PIN && cnt_pin_prev_r;
	wire logic cnt_pin_edge = prev_valid_r
		&& (option_r[OPT_CNT_EDGE] ? cnt_fall : cnt_rise);

	// Flags: a hardware event wins over a software clear
	always_comb
	begin
		intr_ctrl_nxt = wr_ic ? wbyte : intr_ctrl_r;
		intr_ctrl_nxt[IC_RB_FLAG] = intr_ctrl_nxt[IC_RB_FLAG]
			| rb_change;
		intr_ctrl_nxt[IC_EXT_FLAG] = intr_ctrl_nxt[IC_EXT_FLAG]
			| ext_event;
		intr_ctrl_nxt[IC_TMR_FLAG] = intr_ctrl_nxt[IC_TMR_FLAG]
			| COUNTER_OVERFLOW;
		conv_ctrl_nxt = wr_cc ? wbyte : conv_ctrl_r;
		conv_ctrl_nxt[CC_DONE_FLAG] = conv_ctrl_nxt[CC_DONE_FLAG]
			| CONVERSION_DONE;
	end

	// Interrupt request combining
	wire logic [3:0] src_flags = {conv_ctrl_r[CC_DONE_FLAG],
		intr_ctrl_r[IC_TMR_FLAG], intr_ctrl_r[IC_EXT_FLAG],
		intr_ctrl_r[IC_RB_FLAG]};
	wire logic [3:0] src_enables =
		intr_ctrl_r[IC_CONV_EN:IC_RB_EN];
	wire logic any_source = |(src_flags & src_enables);
	wire logic irq_nxt = intr_ctrl_r[IC_GLOBAL_EN]
		&& any_source;
	// Wake does not wait for the global gate, as in sleep
	wire logic wake_nxt = intr_ctrl_r[IC_RB_FLAG]
		&& intr_ctrl_r[IC_RB_EN];

	// Shared prescaler
	wire logic to_wdt = option_r[OPT_ASSIGN_WDT];
	wire logic [2:0] ratio_code =
		option_r[OPT_RATIO_LSB+OPT_RATIO_W-1:OPT_RATIO_LSB];
	wire logic [7:0] pre_mask =
		ratio_mask(ratio_code, to_wdt);
	wire logic cnt_src_tick = option_r[OPT_CNT_SRC]
		? cnt_pin_edge : INSTR_TICK;
	wire logic pre_in = to_wdt
		? WDT_TICK : cnt_src_tick;
	// A zero mask passes every tick: the 1:1 watchdog ratio
	wire logic pre_full = ((pre_cnt_r & pre_mask) == pre_mask);
	wire logic pre_out = pre_in && pre_full;

	always_comb
	begin
		pre_cnt_nxt = pre_cnt_r;
		if (wr_opt)
		begin
			// Reassignment restarts the count so no short period escapes
			pre_cnt_nxt = 8'h00;
		end
		else if (pre_in)
		begin
			pre_cnt_nxt = pre_full ? 8'h00 : pre_cnt_r + 8'h01;
		end
	end

	// Pull-ups only on input pins, all off when option bit 7 set
	wire logic [7:0] pullup_nxt = option_r[OPT_PULLUP_OFF]
		? 8'h00 : portb_dir_r;

	// Analog pin roles
	wire logic [1:0] an_code = analog_cfg_r[1:0];
	wire logic [3:0] an_pins_nxt =
		(an_code == AN_ALL_VDD) ? 4'hF :
		(an_code == AN_ALL_EXTREF) ? 4'h7 :
		(an_code == AN_TWO) ? 4'h3 : 4'h0;
	wire logic ext_vref_nxt = (an_code == AN_ALL_EXTREF);

	// Read data and error captured in the wait state
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			bus_state_r <= BUS_IDLE;
			prdata_r <= '0;
			pslverr_r <= 1'b0;
		end
		else
		begin
			bus_state_r <= bus_state_nxt;
			if (access && (bus_state_r == BUS_WAIT))
			begin
				prdata_r <= PWRITE ? '0 : {24'h000000, read_byte};
				pslverr_r <= !mapped;
			end
		end
	end

	// Flags and prescale count
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			intr_ctrl_r <= RST_INTR_CTRL;
			conv_ctrl_r <= RST_CONV_CTRL;
			pre_cnt_r <= 8'h00;
		end
		else
		begin
			intr_ctrl_r <= intr_ctrl_nxt;
			conv_ctrl_r <= conv_ctrl_nxt;
			pre_cnt_r <= pre_cnt_nxt;
		end
	end

	// Configuration registers, written only in the ready cycle
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			option_r <= RST_OPTION;
			porta_dir_r <= RST_DIR;
			portb_dir_r <= RST_DIR;
			analog_cfg_r <= RST_ANALOG_CFG;
		end
		else if (wr_commit)
		begin
			if (hit_opt)
			begin
				option_r <= wbyte;
			end
			if (hit_pa)
			begin
				porta_dir_r <= wbyte;
			end
			if (hit_pb)
			begin
				portb_dir_r <= wbyte;
			end
			if (hit_an)
			begin
				analog_cfg_r <= wbyte;
			end
		end
	end

	// Reset levels may differ from idle pins; prev_valid_r hides that
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			portb_prev_r <= 8'h00;
			ext_prev_r <= 1'b0;
			cnt_pin_prev_r <= 1'b0;
			prev_valid_r <= 1'b0;
		end
		else
		begin
			portb_prev_r <= PORTB_PINS;
			ext_prev_r <= EXT_INT_PIN;
			cnt_pin_prev_r <= COUNTER_PIN;
			prev_valid_r <= 1'b1;
		end
	end

	// Outputs trail their registers by one cycle
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			irq_r <= 1'b0;
			wake_r <= 1'b0;
			cnt_inc_r <= 1'b0;
			wdt_inc_r <= 1'b0;
			PORTB_PULLUP <= 8'h00;
			PORTA_ANALOG <= 4'hF;
			EXT_VREF <= 1'b0;
		end
		else
		begin
			irq_r <= irq_nxt;
			wake_r <= wake_nxt;
			cnt_inc_r <= pre_out && !to_wdt;
			wdt_inc_r <= pre_out && to_wdt;
			PORTB_PULLUP <= pullup_nxt;
			PORTA_ANALOG <= an_pins_nxt;
			EXT_VREF <= ext_vref_nxt;
		end
	end

	// Ready and error straight from the state register, glitch free
	assign PRDATA = prdata_r;
	assign PSLVERR = pslverr_r && (bus_state_r == BUS_DONE);
	assign PREADY = (bus_state_r == BUS_DONE);
	assign IRQ = irq_r;
	assign WAKE_REQ = wake_r;
	assign COUNTER_INC = cnt_inc_r;
	assign WDT_INC = wdt_inc_r;
	assign PORTA_DIR = porta_dir_r;
	assign PORTB_DIR = portb_dir_r;

endmodule

// ### irq_opt_ctrl_chk.sv
/*
 Port checker for the interrupt and option register bank.
 Bound to irq_opt_ctrl; sees its top-level ports only.
*/
`timescale 1ns/10ps
module irq_opt_ctrl_chk
	import irq_opt_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RSTN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic [DATA_W-1:0] PRDATA,
	input wire logic COUNTER_INC,
	input wire logic WDT_INC,
	input wire logic [7:0] PORTB_DIR,
	input wire logic [7:0] PORTB_PULLUP,
	input wire logic [3:0] PORTA_ANALOG,
	input wire logic EXT_VREF
);
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RSTN);
	// First access cycle; $past is 0 after reset, harmless
	sequence s_access;
		PSEL && PENABLE && !$past(PENABLE);
	endsequence
	sequence s_wait;
		!PREADY ##1 !PREADY ##1 PREADY;
	endsequence
	a_bus_wait: assert property (s_access |-> s_wait)
		else $error("ready not in third access cycle");
	a_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("ready longer than one cycle");
	a_err_ready: assert property (PSLVERR |-> PREADY)
		else $error("error without ready");
	a_rdata_upper: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
		else $error("upper read bits not zero");
	// Pull-ups are registered, so they follow direction one cycle late
	a_pullup_dir: assert property (
		(PORTB_PULLUP & ~$past(PORTB_DIR)) == 8'h00)
		else $error("pull-up on output pin");
	a_analog_code: assert property (
		PORTA_ANALOG inside {4'hF, 4'h7, 4'h3, 4'h0})
		else $error("illegal analog pin map");
	a_vref_map: assert property (EXT_VREF |-> PORTA_ANALOG == 4'h7)
		else $error("reference without code 01 map");
	a_ctr_ratio: assert property (COUNTER_INC |=> !COUNTER_INC)
		else $error("counter ratio below two");
	a_one_route: assert property (!(COUNTER_INC && WDT_INC))
		else $error("prescaler on both paths");
endmodule

// ### irq_opt_ctrl_tb.sv
/*
 Self-checking bench for irq_opt_ctrl: APB master tasks and scenarios.
 Assumes the fixed two wait states; waits stay bounded anyway.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; \
	if ((a) !== (b)) begin miscompares++; \
	$display("[ERR] %0t mismatch", $time); end end
module irq_opt_ctrl_tb;
	import irq_opt_pkg::*;
	logic CLK_SYS = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
	logic [ADDR_W-1:0] PADDR = '0;
	logic [DATA_W-1:0] PWDATA = '0, PRDATA, q;
	logic PREADY, PSLVERR, IRQ, WAKE_REQ, COUNTER_INC, WDT_INC, EXT_VREF, e;
	logic [7:0] PORTB_PINS = 8'h00, PORTA_DIR, PORTB_DIR, PORTB_PULLUP;
	logic EXT_INT_PIN = 1, COUNTER_PIN = 0, INSTR_TICK = 0, WDT_TICK = 0;
	logic COUNTER_OVERFLOW = 0, CONVERSION_DONE = 0;
	logic [3:0] PORTA_ANALOG;
	logic [3:0] am [4] = '{4'hF, 4'h7, 4'h3, 4'h0};
	int miscompares = 0, checked = 0, n;
	irq_opt_ctrl dut_u (.CLK_SYS, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR,
		.PWDATA, .PRDATA, .PREADY, .PSLVERR, .PORTB_PINS, .EXT_INT_PIN,
		.COUNTER_PIN, .INSTR_TICK, .WDT_TICK, .COUNTER_OVERFLOW,
		.CONVERSION_DONE, .IRQ, .WAKE_REQ, .COUNTER_INC, .WDT_INC,
		.PORTA_DIR, .PORTB_DIR, .PORTB_PULLUP, .PORTA_ANALOG, .EXT_VREF);
	initial
	begin
		forever #2.5 CLK_SYS = ~CLK_SYS;
	end
	task automatic wrap_up();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Request held until the edge where PREADY is seen high
	task automatic bus(input logic w, input logic [7:0] i,
		input logic [7:0] d);
		int k;
		@(posedge CLK_SYS);
		PSEL <= 1;
		PWRITE <= w;
		PADDR <= {i, 2'b00};
		PWDATA <= {24'h0, d};
		@(posedge CLK_SYS) PENABLE <= 1;
		k = 0;
		do
		begin
			@(posedge CLK_SYS);
			k++;
		end while (PREADY !== 1'b1 && k < 20);
		q = PRDATA;
		e = PSLVERR;
		PSEL <= 0;
		PENABLE <= 0;
		if (k >= 20)
		begin
			miscompares++;
			wrap_up();
		end
	endtask
	task automatic rdc(input logic [7:0] i, input logic [7:0] x);
		bus(0, i, 8'h00);
		`CHK(q, {24'h0, x})
	endtask
	task automatic wt();
		repeat (4) @(posedge CLK_SYS);
	endtask
	// Counts prescaler pulses; optional seven pin toggles
	task automatic cnt(input bit wdt, input bit tog);
		n = 0;
		for (int i = 0; i < 512; i++)
		begin
			@(posedge CLK_SYS);
			n += wdt ? int'(WDT_INC) : int'(COUNTER_INC);
			if (tog && i < 28 && i % 4 == 0)
				COUNTER_PIN <= ~COUNTER_PIN;
		end
	endtask
	task automatic t_reset();
		rdc(IDX_INTR_CTRL, 8'h00);
		rdc(IDX_OPTION, 8'hFF);
		`CHK(e, 1'b0)
		rdc(IDX_PORTA_DIR, 8'hFF);
		rdc(IDX_PORTB_DIR, 8'hFF);
		rdc(IDX_ANALOG_CFG, 8'h00);
		`CHK(PORTA_ANALOG, 4'hF)
		`CHK(PORTB_PULLUP, 8'h00)
		$display("t_reset done");
	endtask
	task automatic t_regs();
		bus(1, IDX_PORTA_DIR, 8'h5A);
		bus(1, IDX_PORTB_DIR, 8'h3C);
		rdc(IDX_PORTA_DIR, 8'h5A);
		`CHK(PORTA_DIR, 8'h5A)
		`CHK(PORTB_DIR, 8'h3C)
		bus(1, IDX_OPTION, 8'h7F);
		wt();
		`CHK(PORTB_PULLUP, 8'h3C)
		bus(1, IDX_OPTION, 8'hFF);
		wt();
		`CHK(PORTB_PULLUP, 8'h00)
		for (int k = 0; k < 4; k++)
		begin
			bus(1, IDX_ANALOG_CFG, 8'(k));
			wt();
			`CHK(PORTA_ANALOG, am[k])
			`CHK(EXT_VREF, 1'(k == 1))
		end
		bus(1, IDX_UPPER_LAST, 8'h28);
		rdc(IDX_INTR_CTRL, 8'h28);
		bus(0, IDX_UPPER_BASE, 8'h00);
		`CHK(e, 1'b1)
		bus(1, IDX_INTR_CTRL, 8'h00);
		$display("t_regs done");
	endtask
	task automatic t_ext();
		bus(1, IDX_INTR_CTRL, 8'h90);
		@(posedge CLK_SYS) EXT_INT_PIN <= 0;
		wt();
		`CHK(IRQ, 1'b0)
		bus(1, IDX_OPTION, 8'hBF);
		@(posedge CLK_SYS) EXT_INT_PIN <= 1;
		wt();
		`CHK(IRQ, 1'b0)
		@(posedge CLK_SYS) EXT_INT_PIN <= 0;
		wt();
		`CHK(IRQ, 1'b1)
		rdc(IDX_INTR_CTRL, 8'h92);
		bus(1, IDX_INTR_CTRL, 8'h12);
		wt();
		`CHK(IRQ, 1'b0)
		bus(1, IDX_INTR_CTRL, 8'h82);
		wt();
		`CHK(IRQ, 1'b0)
		bus(1, IDX_INTR_CTRL, 8'h92);
		wt();
		`CHK(IRQ, 1'b1)
		bus(1, IDX_INTR_CTRL, 8'h80);
		wt();
		`CHK(IRQ, 1'b0)
		rdc(IDX_INTR_CTRL, 8'h80);
		$display("t_ext done");
	endtask
	task automatic t_rb();
		bus(1, IDX_PORTB_DIR, 8'hDF);
		bus(1, IDX_INTR_CTRL, 8'h08);
		@(posedge CLK_SYS) PORTB_PINS <= 8'h0F;
		wt();
		`CHK(WAKE_REQ, 1'b0)
		@(posedge CLK_SYS) PORTB_PINS <= 8'h2F;
		wt();
		`CHK(WAKE_REQ, 1'b0)
		@(posedge CLK_SYS) PORTB_PINS <= 8'hAF;
		wt();
		`CHK(WAKE_REQ, 1'b1)
		`CHK(IRQ, 1'b0)
		rdc(IDX_INTR_CTRL, 8'h09);
		bus(1, IDX_INTR_CTRL, 8'h08);
		wt();
		`CHK(WAKE_REQ, 1'b0)
		bus(1, IDX_INTR_CTRL, 8'h00);
		$display("t_rb done");
	endtask
	task automatic t_evt();
		bus(1, IDX_INTR_CTRL, 8'hE0);
		@(posedge CLK_SYS) COUNTER_OVERFLOW <= 1;
		@(posedge CLK_SYS) COUNTER_OVERFLOW <= 0;
		wt();
		`CHK(IRQ, 1'b1)
		rdc(IDX_INTR_CTRL, 8'hE4);
		bus(1, IDX_INTR_CTRL, 8'hC0);
		wt();
		`CHK(IRQ, 1'b0)
		@(posedge CLK_SYS) CONVERSION_DONE <= 1;
		@(posedge CLK_SYS) CONVERSION_DONE <= 0;
		wt();
		`CHK(IRQ, 1'b1)
		rdc(IDX_CONV_CTRL, 8'h02);
		bus(1, IDX_INTR_CTRL, 8'h80);
		wt();
		`CHK(IRQ, 1'b0)
		bus(1, IDX_CONV_CTRL, 8'h00);
		bus(1, IDX_INTR_CTRL, 8'h00);
		$display("t_evt done");
	endtask
	// Latency may lose the last pulse of a window
	task automatic t_presc();
		int hi;
		INSTR_TICK <= 1;
		WDT_TICK <= 1;
		for (int k = 0; k < 8; k++)
		begin
			bus(1, IDX_OPTION, 8'h80 | 8'(k));
			cnt(0, 0);
			hi = 512 >> (k + 1);
			`CHK(n inside {[hi - 1 : hi]}, 1'b1)
			bus(1, IDX_OPTION, 8'h88 | 8'(k));
			cnt(1, 0);
			hi = 512 >> k;
			`CHK(n inside {[hi - 1 : hi]}, 1'b1)
		end
		bus(1, IDX_OPTION, 8'hA0);
		cnt(0, 1);
		`CHK(n, 2)
		@(posedge CLK_SYS) COUNTER_PIN <= 0;
		bus(1, IDX_OPTION, 8'hB0);
		cnt(0, 1);
		`CHK(n, 1)
		$display("t_presc done");
	endtask
	initial
	begin
		repeat (20) @(posedge CLK_SYS);
		RSTN <= 1;
		t_reset();
		t_regs();
		t_ext();
		t_rb();
		t_evt();
		t_presc();
		wrap_up();
	end
endmodule
bind irq_opt_ctrl irq_opt_ctrl_chk chk_u (.CLK_SYS, .RSTN, .PSEL, .PENABLE,
	.PREADY, .PSLVERR, .PRDATA, .COUNTER_INC, .WDT_INC, .PORTB_DIR,
	.PORTB_PULLUP, .PORTA_ANALOG, .EXT_VREF);
